// file: logic/cmpref_pkg.sv
// Purpose: Constants for the comparator reference and port control register bank.
// Assumes: AXI4-Lite with 32-bit data; each register takes one aligned word.
// Notes: Registers are 16 bits wide, aux_control only 3 bits; all sit in the low half of the word.
package cmpref_pkg;
    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_REFERENCE_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_PORT_BUFFER_DISABLE = 8'h04;
    localparam logic [7:0] ADDR_AUX_CONTROL = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] RST_REFERENCE_CONTROL = 16'h0000;
    localparam logic [15:0] RST_PORT_BUFFER_DISABLE = 16'h0000;
    localparam logic [2:0] RST_AUX_CONTROL = 3'h0;

    // ------------------------------------------------------------------
    // Field positions of reference_control
    // ------------------------------------------------------------------
    localparam int REF_ACCURACY_BIT = 15;
    localparam int REF_LEVEL_HI = 14;
    localparam int REF_LEVEL_LO = 13;
    localparam int UPPER_TAP_HI = 12;
    localparam int UPPER_TAP_LO = 8;
    localparam int SOURCE_HI = 7;
    localparam int SOURCE_LO = 6;
    localparam int TERMINAL_SEL_BIT = 5;
    localparam int LOWER_TAP_HI = 4;
    localparam int LOWER_TAP_LO = 0;

    // ------------------------------------------------------------------
    // Field positions of aux_control and status
    // ------------------------------------------------------------------
    localparam int AUX_EXCHANGE_BIT = 0;
    localparam int AUX_MANUAL_EN_BIT = 1;
    localparam int AUX_MANUAL_LEVEL_BIT = 2;
    localparam int STAT_RESULT_BIT = 0;
    localparam int STAT_RAW_BIT = 1;
    localparam int STAT_TAP_LO = 2;

    // ------------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] LEVEL_OFF = 2'h0;
    localparam logic [1:0] SRC_OFF = 2'h0;
    localparam logic [1:0] SRC_SUPPLY_LADDER = 2'h1;
    localparam logic [1:0] SRC_SHARED_LADDER = 2'h2;
    localparam logic [1:0] SRC_SHARED_DIRECT = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : cmpref_pkg

// file: logic/cmpref_decode.sv
// Purpose: Decodes the reference control word into ladder, source and terminal controls.
// Assumes: cmp_raw is already synchronised to clk.
// Notes: Purely combinational; the caller registers every output.
`timescale 1ns/1ns
module cmpref_decode (
    input wire logic [15:0] ctrl,
    input wire logic [2:0] aux,
    input wire logic cmp_raw,
    output logic cmp_out,
    output logic ref_request,
    output logic [4:0] ladder_tap,
    output logic ladder_from_supply,
    output logic ladder_from_shared,
    output logic shared_direct,
    output logic ref_to_plus,
    output logic ref_to_minus
);
    logic exchange;
    logic use_upper;
    logic [1:0] src;

    always_comb begin
        exchange = aux[cmpref_pkg::AUX_EXCHANGE_BIT];
        src = ctrl[cmpref_pkg::SOURCE_HI:cmpref_pkg::SOURCE_LO];
        // Exchange inverts the comparator output seen by the rest of the block.
        cmp_out = cmp_raw ^ exchange;
        ref_request = ctrl[cmpref_pkg::REF_LEVEL_HI:cmpref_pkg::REF_LEVEL_LO]
                      != cmpref_pkg::LEVEL_OFF;
        // Manual choice overrides the output state except in direct mode.
        if (aux[cmpref_pkg::AUX_MANUAL_EN_BIT] && src != cmpref_pkg::SRC_SHARED_DIRECT) begin
            use_upper = aux[cmpref_pkg::AUX_MANUAL_LEVEL_BIT];
        end else begin
            use_upper = cmp_out;
        end
        if (use_upper) begin
            ladder_tap = ctrl[cmpref_pkg::UPPER_TAP_HI:cmpref_pkg::UPPER_TAP_LO];
        end else begin
            ladder_tap = ctrl[cmpref_pkg::LOWER_TAP_HI:cmpref_pkg::LOWER_TAP_LO];
        end
        ladder_from_supply = src == cmpref_pkg::SRC_SUPPLY_LADDER;
        ladder_from_shared = src == cmpref_pkg::SRC_SHARED_LADDER;
        shared_direct = src == cmpref_pkg::SRC_SHARED_DIRECT;
        ref_to_plus = ctrl[cmpref_pkg::TERMINAL_SEL_BIT] == exchange;
        ref_to_minus = ctrl[cmpref_pkg::TERMINAL_SEL_BIT] != exchange;
    end
endmodule : cmpref_decode

// file: logic/cmpref_regs.sv
// Purpose: AXI4-Lite register bank steering a comparator reference generator and pin buffers.
// Assumes: comparator_result comes from the analog core, asynchronous to clk.
// Notes: Outputs are registered from the next register values, so they change at the
//        same edge that stores a write.
//
// The AXI4-Lite register port and the address map were left to the implementer.
`timescale 1ns/1ns
// Operation
// - Request reference only for nonzero level
// - Accuracy bit: static or clocked mode
// - Level field: off, 1.5, 2.0, 2.5 V
// - Upper tap used while output high
// - Lower tap used while output low
// - Source field picks supply, shared, direct, off
// - Terminal bit equal exchange gives plus
// - Port bit set disables channel input buffer
// - Manual choice bit overrides output tap selection; the code ignores it while the source field selects direct
// - Exchange swaps inputs and inverts output
module cmpref_regs (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic comparator_result,
    output logic comparator_out,
    output logic input_exchange,
    output logic ref_request,
    output logic ref_accuracy_mode,
    output logic [1:0] ref_level_select,
    output logic [4:0] ladder_tap,
    output logic ladder_from_supply,
    output logic ladder_from_shared,
    output logic shared_direct,
    output logic ref_to_plus,
    output logic ref_to_minus,
    output logic [15:0] pin_buffer_off
);
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                            input logic [3:0] strb);
        logic [15:0] res;
        res = old;
        if (strb[0]) begin
            res[7:0] = data[7:0];
        end
        if (strb[1]) begin
            res[15:8] = data[15:8];
        end
        return res;
    endfunction : merge16

    function automatic logic mapped(input logic [7:0] addr);
        return addr == cmpref_pkg::ADDR_REFERENCE_CONTROL ||
               addr == cmpref_pkg::ADDR_PORT_BUFFER_DISABLE ||
               addr == cmpref_pkg::ADDR_AUX_CONTROL ||
               addr == cmpref_pkg::ADDR_STATUS;
    endfunction : mapped

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [15:0] reference_control;
    logic [15:0] port_buffer_disable;
    logic [2:0] aux_control;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic res_meta;
    logic res_sync;
    logic [15:0] next_reference_control;
    logic [15:0] next_port_buffer_disable;
    logic [2:0] next_aux_control;
    logic next_aw_held;
    logic [7:0] next_aw_addr;
    logic next_w_held;
    logic [31:0] next_w_data;
    logic [3:0] next_w_strb;
    logic next_awready;
    logic next_wready;
    logic [1:0] next_bresp;
    logic next_bvalid;
    logic next_arready;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic next_rvalid;
    logic dec_cmp_out;
    logic dec_ref_request;
    logic [4:0] dec_ladder_tap;
    logic dec_from_supply;
    logic dec_from_shared;
    logic dec_direct;
    logic dec_to_plus;
    logic dec_to_minus;

    // ------------------------------------------------------------------
    // Comparator result synchroniser
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            res_meta <= 1'b0;
            res_sync <= 1'b0;
        end else begin
            res_meta <= comparator_result;
            res_sync <= res_meta;
        end
    end

    // ------------------------------------------------------------------
    // Decode of the values the registers take at the next edge
    // ------------------------------------------------------------------
    cmpref_decode u_decode (
        .ctrl(next_reference_control),
        .aux(next_aux_control),
        .cmp_raw(res_sync),
        .cmp_out(dec_cmp_out),
        .ref_request(dec_ref_request),
        .ladder_tap(dec_ladder_tap),
        .ladder_from_supply(dec_from_supply),
        .ladder_from_shared(dec_from_shared),
        .shared_direct(dec_direct),
        .ref_to_plus(dec_to_plus),
        .ref_to_minus(dec_to_minus)
    );

    // ------------------------------------------------------------------
    // Bus slave and register next values
    // ------------------------------------------------------------------
    always_comb begin
        next_reference_control = reference_control;
        next_port_buffer_disable = port_buffer_disable;
        next_aux_control = aux_control;
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bresp = s_axi_bresp;
        next_bvalid = s_axi_bvalid;
        next_arready = s_axi_arready;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        next_rvalid = s_axi_rvalid;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        // The write is carried out once both halves are held and no response waits.
        if (aw_held && w_held && !s_axi_bvalid) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = mapped(aw_addr) ? cmpref_pkg::RESP_OKAY : cmpref_pkg::RESP_SLVERR;
            unique case (aw_addr)
                cmpref_pkg::ADDR_REFERENCE_CONTROL: begin
                    next_reference_control = merge16(reference_control, w_data, w_strb);
                end
                cmpref_pkg::ADDR_PORT_BUFFER_DISABLE: begin
                    next_port_buffer_disable = merge16(port_buffer_disable, w_data, w_strb);
                end
                cmpref_pkg::ADDR_AUX_CONTROL: begin
                    if (w_strb[0]) begin
                        next_aux_control = w_data[2:0];
                    end
                end
                default: begin
                end
            endcase
        end
        next_awready = !next_aw_held && !next_bvalid;
        next_wready = !next_w_held && !next_bvalid;
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
            next_arready = 1'b1;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_arready = 1'b0;
            next_rvalid = 1'b1;
            next_rresp = mapped(s_axi_araddr) ? cmpref_pkg::RESP_OKAY : cmpref_pkg::RESP_SLVERR;
            next_rdata = 32'h0000_0000;
            unique case (s_axi_araddr)
                cmpref_pkg::ADDR_REFERENCE_CONTROL: begin
                    next_rdata[15:0] = reference_control;
                end
                cmpref_pkg::ADDR_PORT_BUFFER_DISABLE: begin
                    next_rdata[15:0] = port_buffer_disable;
                end
                cmpref_pkg::ADDR_AUX_CONTROL: begin
                    next_rdata[2:0] = aux_control;
                end
                cmpref_pkg::ADDR_STATUS: begin
                    next_rdata[cmpref_pkg::STAT_RESULT_BIT] = comparator_out;
                    next_rdata[cmpref_pkg::STAT_RAW_BIT] = res_sync;
                    next_rdata[cmpref_pkg::STAT_TAP_LO +: 5] = ladder_tap;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reference_control <= cmpref_pkg::RST_REFERENCE_CONTROL;
            port_buffer_disable <= cmpref_pkg::RST_PORT_BUFFER_DISABLE;
            aux_control <= cmpref_pkg::RST_AUX_CONTROL;
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bresp <= cmpref_pkg::RESP_OKAY;
            s_axi_bvalid <= 1'b0;
            s_axi_arready <= 1'b1;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= cmpref_pkg::RESP_OKAY;
            s_axi_rvalid <= 1'b0;
        end else begin
            reference_control <= next_reference_control;
            port_buffer_disable <= next_port_buffer_disable;
            aux_control <= next_aux_control;
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bresp <= next_bresp;
            s_axi_bvalid <= next_bvalid;
            s_axi_arready <= next_arready;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
            s_axi_rvalid <= next_rvalid;
        end
    end

    // ------------------------------------------------------------------
    // Registered analog and pin controls
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            comparator_out <= 1'b0;
            input_exchange <= 1'b0;
            ref_request <= 1'b0;
            ref_accuracy_mode <= 1'b0;
            ref_level_select <= 2'h0;
            ladder_tap <= 5'h00;
            ladder_from_supply <= 1'b0;
            ladder_from_shared <= 1'b0;
            shared_direct <= 1'b0;
            ref_to_plus <= 1'b1;
            ref_to_minus <= 1'b0;
            pin_buffer_off <= 16'h0000;
        end else begin
            comparator_out <= dec_cmp_out;
            input_exchange <= next_aux_control[cmpref_pkg::AUX_EXCHANGE_BIT];
            ref_request <= dec_ref_request;
            ref_accuracy_mode <= next_reference_control[cmpref_pkg::REF_ACCURACY_BIT];
            ref_level_select <= next_reference_control[cmpref_pkg::REF_LEVEL_HI:
                                                       cmpref_pkg::REF_LEVEL_LO];
            ladder_tap <= dec_ladder_tap;
            ladder_from_supply <= dec_from_supply;
            ladder_from_shared <= dec_from_shared;
            shared_direct <= dec_direct;
            ref_to_plus <= dec_to_plus;
            ref_to_minus <= dec_to_minus;
            pin_buffer_off <= next_port_buffer_disable;
        end
    end
endmodule : cmpref_regs

// file: sim/cmpref_core_model.sv
// Purpose: Behavioural analog comparator core facing the register bank.
// Assumes: The bench commands which input is truly the higher one.
// Notes: Output moves a few ns after its cause, unrelated to clk.
`timescale 1ns/1ns
module cmpref_core_model (
    input wire logic plus_higher,
    input wire logic input_exchange,
    output logic comparator_result
);
    // Swapped inputs invert the raw decision before it reaches the bank.
    assign #7 comparator_result = plus_higher ^ input_exchange;
endmodule : cmpref_core_model

// file: sim/cmpref_regs_asserts.sv
// Purpose: Port-level checks of the comparator reference register bank.
// Assumes: One clock domain, reset active high.
// Notes: Bound into every instance of the bank.
`timescale 1ns/1ns
module cmpref_regs_chk (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic comparator_result,
    input wire logic comparator_out,
    input wire logic input_exchange,
    input wire logic ref_request,
    input wire logic [1:0] ref_level_select,
    input wire logic ladder_from_supply,
    input wire logic ladder_from_shared,
    input wire logic shared_direct,
    input wire logic ref_to_plus,
    input wire logic ref_to_minus
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    chk_req_level: assert property (ref_request == (ref_level_select != 2'h0))
        else $error("reference request disagrees with level");
    chk_src_onehot: assert property ($onehot0({ladder_from_supply, ladder_from_shared,
        shared_direct})) else $error("more than one source active");
    chk_term_pair: assert property (ref_to_plus ^ ref_to_minus)
        else $error("reference on both or no terminal");
    chk_out_exch: assert property (((comparator_result ^ input_exchange)
        && $stable(comparator_result) && $stable(input_exchange)) [*5] |-> comparator_out)
        else $error("output not corrected for exchange");
    chk_rd_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_wr_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write answer dropped");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read answer dropped");
endmodule : cmpref_regs_chk
bind cmpref_regs cmpref_regs_chk i_cmpref_regs_chk (.clk, .sys_rst, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .comparator_result, .comparator_out, .input_exchange, .ref_request,
    .ref_level_select, .ladder_from_supply, .ladder_from_shared, .shared_direct,
    .ref_to_plus, .ref_to_minus);

// file: sim/tb_comparator_reference_and_port_control.sv
// Purpose: Self-checking bench of the comparator reference register bank.
// Assumes: AXI4-Lite master tasks, one transfer of each kind at a time.
// Notes: Random traffic from a fixed seed plus corner cases.
`timescale 1ns/1ns
module tb_comparator_reference_and_port_control;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, plus_higher = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, ref_level_select;
    logic comparator_result, comparator_out, input_exchange, ref_request;
    logic ref_accuracy_mode, ladder_from_supply, ladder_from_shared, shared_direct;
    logic ref_to_plus, ref_to_minus;
    logic [4:0] ladder_tap;
    logic [15:0] pin_buffer_off, c;
    logic [2:0] x;
    logic [1:0] r;
    logic [31:0] d;
    int err_total = 0;
    int comparisons = 0;
    cmpref_regs i_cmpref_regs (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .comparator_result,
        .comparator_out, .input_exchange, .ref_request, .ref_accuracy_mode,
        .ref_level_select, .ladder_tap, .ladder_from_supply, .ladder_from_shared,
        .shared_direct, .ref_to_plus, .ref_to_minus, .pin_buffer_off);
    cmpref_core_model i_cmpref_core_model (.plus_higher, .input_exchange, .comparator_result);
    initial begin
        forever #20 clk = ~clk;
    end
    task check_val(input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : check_val
    task end_of_test();
        $display("comparisons=%0d mismatches=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_of_test
    task wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= v;
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    function automatic logic [4:0] exp_tap(logic [15:0] k, logic [2:0] m, logic o);
        logic ch;
        ch = (m[1] && k[7:6] != 2'h3) ? m[2] : o;
        return ch ? k[12:8] : k[4:0];
    endfunction : exp_tap
    initial begin
        #(40 * 20000);
        err_total++;
        end_of_test();
    end
    initial begin
        void'($urandom(80));
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        // ------
        // Reset values, refusals and byte strobes.
        // ------
        check_val(32'h0040_0000, {ref_to_plus, ref_to_minus, pin_buffer_off, ladder_tap});
        rd(cmpref_pkg::ADDR_REFERENCE_CONTROL);
        check_val(32'h0, d);
        rd(cmpref_pkg::ADDR_PORT_BUFFER_DISABLE);
        check_val(32'h0, d);
        wr(8'h10, 32'hffff, 4'hf);
        check_val(cmpref_pkg::RESP_SLVERR, r);
        rd(8'h10);
        check_val(cmpref_pkg::RESP_SLVERR, r);
        check_val(32'h0, d);
        wr(cmpref_pkg::ADDR_REFERENCE_CONTROL, 32'hffff_ffff, 4'h1);
        rd(cmpref_pkg::ADDR_REFERENCE_CONTROL);
        check_val(32'h00ff, d);
        $display("test reset_and_refusal done");
        for (int i = 0; i < 8; i++) begin
            wr(cmpref_pkg::ADDR_REFERENCE_CONTROL, {16'h0, i[2:0], 13'h0}, 4'hf);
            check_val(i[1:0], ref_level_select);
            check_val(i[1:0] != 2'h0, ref_request);
            check_val(i[2], ref_accuracy_mode);
        end
        for (int i = 0; i < 4; i++) begin
            wr(cmpref_pkg::ADDR_REFERENCE_CONTROL, i << 6, 4'hf);
            check_val(3'(4'h8 >> i),
                {ladder_from_supply, ladder_from_shared, shared_direct});
        end
        for (int i = 0; i < 4; i++) begin
            wr(cmpref_pkg::ADDR_AUX_CONTROL, i & 1, 4'hf);
            wr(cmpref_pkg::ADDR_REFERENCE_CONTROL, (i >> 1) << 5, 4'hf);
            check_val({i[1] == i[0], i[1] != i[0]}, {ref_to_plus, ref_to_minus});
            check_val(i[0], input_exchange);
        end
        $display("test level_source_terminal done");
        for (int i = 0; i < 32; i++) begin
            c = (i < 4) ? {3'h0, 5'h15, 2'(i), 6'h0a} : 16'($urandom);
            x = (i < 4) ? 3'(i + 2) : 3'($urandom);
            plus_higher <= 1'($urandom);
            wr(cmpref_pkg::ADDR_AUX_CONTROL, x, 4'hf);
            wr(cmpref_pkg::ADDR_REFERENCE_CONTROL, c, 4'hf);
            repeat (5) @(posedge clk);
            check_val(plus_higher, comparator_out);
            check_val(exp_tap(c, x, plus_higher), ladder_tap);
            rd(cmpref_pkg::ADDR_REFERENCE_CONTROL);
            check_val(c, d);
            rd(cmpref_pkg::ADDR_STATUS);
            check_val({exp_tap(c, x, plus_higher), plus_higher ^ x[0], plus_higher}, d);
            rd(cmpref_pkg::ADDR_AUX_CONTROL);
            check_val(x, d);
        end
        $display("test ladder_taps done");
        for (int i = 0; i < 12; i++) begin
            c = (i == 0) ? 16'h8001 : 16'($urandom);
            wr(cmpref_pkg::ADDR_PORT_BUFFER_DISABLE, {16'hffff, c}, 4'hf);
            check_val(c, pin_buffer_off);
            wr(cmpref_pkg::ADDR_STATUS, 32'h0, 4'hf);
            check_val(cmpref_pkg::RESP_OKAY, r);
            rd(cmpref_pkg::ADDR_PORT_BUFFER_DISABLE);
            check_val(c, d);
        end
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        check_val(32'h0040_0000, {ref_to_plus, ref_to_minus, pin_buffer_off, ladder_tap});
        $display("test port_buffers done");
        end_of_test();
    end
endmodule : tb_comparator_reference_and_port_control
